// *** rtl/wtc_pkg.sv ***
package wtc_pkg;

  // ****************************************
  // Register addresses (7-bit SPI address)
  // ****************************************
  localparam logic [6:0] WTC_ADDR_WAKE_INPUT = 7'h06;  // wake_input_control
  localparam logic [6:0] WTC_ADDR_WAKE_SOURCE = 7'h07; // wake_source_control
  localparam logic [6:0] WTC_ADDR_PIN_PULL = 7'h08;    // wake_pin_pull_control
  localparam logic [6:0] WTC_ADDR_TIMER = 7'h0C;       // periodic_timer_control
  localparam logic [6:0] WTC_ADDR_SCRATCH = 7'h1E;     // system_scratch_byte
  localparam logic [6:0] WTC_ADDR_SUPPLY = 7'h41;      // supply_fail_status
  localparam logic [6:0] WTC_ADDR_DEVICE = 7'h43;      // device status with fail counter

  // ****************************************
  // Writable bit masks, reserved bits are zero
  // ****************************************
  localparam logic [7:0] WTC_WAKE_INPUT_MASK = 8'h44;
  localparam logic [7:0] WTC_WAKE_SOURCE_MASK = 8'h01;
  localparam logic [7:0] WTC_PIN_PULL_MASK = 8'h03;
  localparam logic [7:0] WTC_TIMER_MASK = 8'h07;
  localparam logic [7:0] WTC_SCRATCH_MASK = 8'hFF;

  // ****************************************
  // Power-on values, also loaded by soft reset except the scratch byte
  // ****************************************
  localparam logic [7:0] WTC_WAKE_INPUT_RST = 8'h00;
  localparam logic [7:0] WTC_WAKE_SOURCE_RST = 8'h01;
  localparam logic [7:0] WTC_PIN_PULL_RST = 8'h00;
  localparam logic [7:0] WTC_TIMER_RST = 8'h00;
  localparam logic [7:0] WTC_SCRATCH_RST = 8'h00;

  // Bits that survive a restart of the device
  localparam logic [7:0] WTC_WAKE_INPUT_KEEP = 8'h40;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int WTC_TIMER_WAKE_BIT = 6;
  localparam int WTC_WD_STOP_BIT = 2;
  localparam int WTC_PIN_WAKE_BIT = 0;
  localparam int WTC_SPI_FAIL_BIT = 1;
  localparam int WTC_WD_CNT_LSB = 2;

  // ****************************************
  // Status register layouts
  // ****************************************
  localparam logic [7:0] WTC_SUPPLY_RC_MASK = 8'hFD;
  localparam logic [7:0] WTC_SUPPLY_RO_MASK = 8'h00;
  localparam logic [7:0] WTC_SUPPLY_POR_VAL = 8'h80;  // Power-on flag set after POR
  localparam logic [7:0] WTC_SUPPLY_SOFT_KEEP = 8'h80;
  localparam logic [7:0] WTC_DEVICE_RC_MASK = 8'hF3;
  localparam logic [7:0] WTC_DEVICE_RO_MASK = 8'h0C;
  localparam logic [7:0] WTC_DEVICE_POR_VAL = 8'h00;
  localparam logic [7:0] WTC_DEVICE_SOFT_KEEP = 8'h00;
  localparam logic [1:0] WTC_WD_CNT_MAX = 2'h2;       // Code 11 is never reached

  // ****************************************
  // SPI frame and periodic timer periods
  // ****************************************
  localparam logic [4:0] WTC_FRAME_BITS = 5'h10;
  localparam logic [4:0] WTC_ADDR_BITS = 5'h07;
  localparam logic [2:0] WTC_PERIOD_RESERVED = 3'h7;
  localparam logic [10:0] WTC_PERIOD_MS [0:6] = '{
    11'h00A, 11'h014, 11'h032, 11'h064, 11'h0C8, 11'h3E8, 11'h7D0
  };

  // Frame as received: data byte in bits 15:8, access mode in bit 7
  typedef struct packed {
    logic [7:0] data;
    logic clear;
    logic [6:0] addr;
  } wtc_frame_type;

  // Control fields that steer the wake and watchdog logic
  typedef struct packed {
    logic periodic_timer_wake_enable;
    logic watchdog_stop_mode_disable;
    logic wake_pin_wake_enable;
    logic [1:0] wake_pin_pull_select;
    logic [2:0] periodic_timer_period;
  } wtc_ctrl_type;

  // Synchronised SPI pins
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } wtc_spi_type;

  // State of the register bank, except the sync stages and status bytes
  typedef struct packed {
    logic cs_n_prev;
    logic sck_prev;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic miso;
    logic miso_oe;
    logic [7:0] wake_input;
    logic [7:0] wake_source;
    logic [7:0] pin_pull;
    logic [7:0] timer;
    logic [7:0] scratch;
    logic [1:0] wd_cnt;
  } wtc_core_state_type;

endpackage : wtc_pkg

// *** rtl/wtc_sync.sv ***
`timescale 1ns/1ps

// ****************************************
// Two-stage synchroniser for pin inputs
// ****************************************
module wtc_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // Both stages in one packed state
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } wtc_sync_state_type;

  wtc_sync_state_type s_r;
  wtc_sync_state_type s_nxt;

  initial begin
    if (WIDTH < 1) $error("wtc_sync: WIDTH must be at least 1");
  end

  // The first stage feeds only the second stage
  always_comb begin
    s_nxt.meta = async_i;
    s_nxt.stable = s_r.meta;
  end

  // Both stages reset to the idle pin levels, so no false edge follows reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= {RESET_VAL, RESET_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = s_r.stable;

endmodule : wtc_sync

// *** rtl/wtc_status_byte.sv ***
`timescale 1ns/1ps

// ****************************************
// One status byte with sticky clearable bits
// ****************************************
module wtc_status_byte #(
  parameter logic [7:0] RC_MASK = 8'hFF,
  parameter logic [7:0] RO_MASK = 8'h00,
  parameter logic [7:0] POR_VAL = 8'h00,
  parameter logic [7:0] SOFT_KEEP = 8'h00
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  input wire logic [7:0] event_i,
  input wire logic [7:0] ro_i,
  input wire logic clear_i,
  output logic [7:0] value_o
);

  typedef struct packed {
    logic [7:0] flags;
  } wtc_status_state_type;

  wtc_status_state_type s_r;
  wtc_status_state_type s_nxt;

  initial begin
    if ((RC_MASK & RO_MASK) != 8'h00) $error("wtc_status_byte: masks overlap");
  end

  // Clear only touches clearable bits; a new event wins over the clear
  always_comb begin
    s_nxt = s_r;
    if (soft_reset_i) begin
      s_nxt.flags = s_r.flags & SOFT_KEEP;
    end else if (clear_i) begin
      s_nxt.flags = 8'h00;  // see (R14) see (R15)
    end
    s_nxt.flags = (s_nxt.flags | event_i) & RC_MASK;  // see (R16)
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r.flags <= POR_VAL & RC_MASK;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Read-only bits show live hardware state, reserved bits read zero
  assign value_o = s_r.flags | (ro_i & RO_MASK);

endmodule : wtc_status_byte

// *** rtl/wtc_regs.sv ***
// Overview of operation
// (R1) Timer wake enabled only when bit6 set
// (R2) Bit2 stops watchdog in stop mode
// (R3) Reserved bits always read zero
// (R4) Bit0 enables wake pin, resets one
// (R5) Pull field: none, down, up, auto
// (R6) Period codes 10ms to 2s, 111 reserved
// (R7) Scratch byte drives no device function
// (R8) Scratch cleared only by power-on reset
// (R9) Scratch writable, survives fail-safe and restart
// (R10) Frame: address, mode bit, data byte
// (R11) Data byte ignored for status registers
// (R12) Data bits sit in frame bits 15:8
// (R13) Mode zero reads status, no change
// (R14) Mode one clears all clearable status bits
// (R15) Read-only bits survive clear command
// (R16) Flags change only by event, SPI clear or reset
// (R17) Restart keeps timer wake, clears rest
// (R18) Restart keeps wake pin enable
// (R19) Restart keeps period and pull fields
// (R20) Writes to reserved bits are ignored
// (R21) Fail counter cleared by good trigger
`timescale 1ns/1ps

module wtc_regs (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  input wire logic restart_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic wd_stop_hw_update_i,
  input wire logic wd_stop_hw_value_i,
  input wire logic watchdog_fail_counter_event_i,
  input wire logic wd_trigger_ok_i,
  input wire logic [7:0] supply_event_i,
  input wire logic [7:0] device_event_i,
  output wtc_pkg::wtc_ctrl_type ctrl_o,
  output logic periodic_timer_period_valid_o,
  output logic [10:0] periodic_timer_period_ms_o
);

  // ****************************************
  // Declarations
  // ****************************************
  wtc_pkg::wtc_core_state_type s_r;   // Registered state, except the sync stages and status bytes
  wtc_pkg::wtc_core_state_type s_nxt; // Its next value
  wtc_pkg::wtc_spi_type spi_s;        // Synchronised pins
  wtc_pkg::wtc_frame_type frame;      // Frame view of the shift register
  logic [7:0] low_byte;               // First byte as it completes
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic commit;                       // Whole 16-bit frame ended
  logic spi_fail;                     // Frame of wrong length
  logic supply_clr;
  logic device_clr;
  logic [7:0] supply_val;
  logic [7:0] device_val;
  logic [7:0] device_ev;
  logic [7:0] device_ro;
  logic [7:0] rd_byte;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wtc_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h7)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({spi_cs_n_i, spi_sck_i, spi_mosi_i}),
    .sync_o(spi_s)
  );

  // ****************************************
  // Frame edge and completion decode
  // ****************************************
  // Edges are taken from the stable stage only, never the meta stage
  assign sck_rise = spi_s.sck & ~s_r.sck_prev & ~spi_s.cs_n;
  assign sck_fall = ~spi_s.sck & s_r.sck_prev & ~spi_s.cs_n;
  assign cs_fall = ~spi_s.cs_n & s_r.cs_n_prev;
  assign cs_rise = spi_s.cs_n & ~s_r.cs_n_prev;
  assign frame = s_r.shift_in;                                  // see (R12)
  assign low_byte = {spi_s.mosi, s_r.shift_in[15:9]};
  assign commit = cs_rise && (s_r.bit_cnt == wtc_pkg::WTC_FRAME_BITS);  // see (R10)
  assign spi_fail = cs_rise && (s_r.bit_cnt != wtc_pkg::WTC_FRAME_BITS);

  // Clear only with mode bit one; the data byte plays no part
  assign supply_clr = commit && frame.clear
                      && (frame.addr == wtc_pkg::WTC_ADDR_SUPPLY);  // see (R11) see (R14)
  assign device_clr = commit && frame.clear
                      && (frame.addr == wtc_pkg::WTC_ADDR_DEVICE);  // see (R14)

  // ****************************************
  // Read data selection
  // ****************************************
  // Address is known at the eighth rising edge, before the data byte shifts out
  always_comb begin
    unique case (low_byte[6:0])
      wtc_pkg::WTC_ADDR_WAKE_INPUT: rd_byte = s_r.wake_input;
      wtc_pkg::WTC_ADDR_WAKE_SOURCE: rd_byte = s_r.wake_source;
      wtc_pkg::WTC_ADDR_PIN_PULL: rd_byte = s_r.pin_pull;
      wtc_pkg::WTC_ADDR_TIMER: rd_byte = s_r.timer;
      wtc_pkg::WTC_ADDR_SCRATCH: rd_byte = s_r.scratch;
      wtc_pkg::WTC_ADDR_SUPPLY: rd_byte = supply_val;
      wtc_pkg::WTC_ADDR_DEVICE: rd_byte = device_val;
      default: rd_byte = 8'h00;  // Unmapped addresses read zero
    endcase
  end

  // ****************************************
  // Main state update
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.cs_n_prev = spi_s.cs_n;
    s_nxt.sck_prev = spi_s.sck;
    s_nxt.miso_oe = ~spi_s.cs_n;

    // Serial shift, LSB of the frame first
    if (cs_fall) begin
      s_nxt.bit_cnt = 5'h00;
      s_nxt.shift_out = 8'h00;
      s_nxt.miso = 1'b0;
    end else if (sck_rise) begin
      s_nxt.shift_in = {spi_s.mosi, s_r.shift_in[15:1]};
      if (s_r.bit_cnt <= wtc_pkg::WTC_FRAME_BITS) begin
        s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;  // Saturates one past a full frame
      end
      if (s_r.bit_cnt == wtc_pkg::WTC_ADDR_BITS) begin
        s_nxt.shift_out = rd_byte;  // Snapshot taken before any clear, see (R13)
      end
    end else if (sck_fall) begin
      s_nxt.miso = s_r.shift_out[0];
      s_nxt.shift_out = {1'b0, s_r.shift_out[7:1]};
    end

    // Register writes; reserved bits are masked away
    if (commit && frame.clear) begin
      unique case (frame.addr)
        wtc_pkg::WTC_ADDR_WAKE_INPUT:
          s_nxt.wake_input = frame.data & wtc_pkg::WTC_WAKE_INPUT_MASK;  // see (R20)
        wtc_pkg::WTC_ADDR_WAKE_SOURCE:
          s_nxt.wake_source = frame.data & wtc_pkg::WTC_WAKE_SOURCE_MASK;  // see (R3)
        wtc_pkg::WTC_ADDR_PIN_PULL:
          s_nxt.pin_pull = frame.data & wtc_pkg::WTC_PIN_PULL_MASK;
        wtc_pkg::WTC_ADDR_TIMER:
          s_nxt.timer = frame.data & wtc_pkg::WTC_TIMER_MASK;
        wtc_pkg::WTC_ADDR_SCRATCH:
          s_nxt.scratch = frame.data & wtc_pkg::WTC_SCRATCH_MASK;  // see (R9)
        default: begin
          // Status and unmapped addresses store nothing here
        end
      endcase
    end

    // Hardware may move the watchdog stop bit; it wins over a write
    if (wd_stop_hw_update_i) begin
      s_nxt.wake_input[wtc_pkg::WTC_WD_STOP_BIT] = wd_stop_hw_value_i;  // see (R2)
    end

    // Restart keeps only the documented survivors
    if (restart_i) begin
      s_nxt.wake_input = s_r.wake_input & wtc_pkg::WTC_WAKE_INPUT_KEEP;  // see (R17)
      s_nxt.wake_source = s_r.wake_source;  // see (R18)
      s_nxt.pin_pull = s_r.pin_pull;        // see (R19)
      s_nxt.timer = s_r.timer;
    end

    // Soft reset restores defaults but leaves the scratch byte alone
    if (soft_reset_i) begin
      s_nxt.wake_input = wtc_pkg::WTC_WAKE_INPUT_RST;
      s_nxt.wake_source = wtc_pkg::WTC_WAKE_SOURCE_RST;  // see (R4)
      s_nxt.pin_pull = wtc_pkg::WTC_PIN_PULL_RST;
      s_nxt.timer = wtc_pkg::WTC_TIMER_RST;
      s_nxt.scratch = s_r.scratch;  // see (R8)
    end

    // Watchdog fail counter: a fail event wins over a good trigger
    if (soft_reset_i) begin
      s_nxt.wd_cnt = 2'h0;
    end else if (watchdog_fail_counter_event_i) begin
      if (s_r.wd_cnt < wtc_pkg::WTC_WD_CNT_MAX) begin
        s_nxt.wd_cnt = s_r.wd_cnt + 2'h1;
      end
    end else if (wd_trigger_ok_i) begin
      s_nxt.wd_cnt = 2'h0;  // see (R21)
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0;
      s_r.cs_n_prev <= 1'b1;
      s_r.sck_prev <= 1'b1;
      s_r.wake_source <= wtc_pkg::WTC_WAKE_SOURCE_RST;
      s_r.scratch <= wtc_pkg::WTC_SCRATCH_RST;  // see (R8)
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Status registers
  // ****************************************
  // Wrong-length frames are flagged so software can see the lost command
  always_comb begin
    device_ev = device_event_i & wtc_pkg::WTC_DEVICE_RC_MASK;
    device_ev[wtc_pkg::WTC_SPI_FAIL_BIT] = device_event_i[wtc_pkg::WTC_SPI_FAIL_BIT] | spi_fail;
    device_ro = 8'h00;
    device_ro[wtc_pkg::WTC_WD_CNT_LSB +: 2] = s_r.wd_cnt;
  end

  wtc_status_byte #(
    .RC_MASK(wtc_pkg::WTC_SUPPLY_RC_MASK),
    .RO_MASK(wtc_pkg::WTC_SUPPLY_RO_MASK),
    .POR_VAL(wtc_pkg::WTC_SUPPLY_POR_VAL),
    .SOFT_KEEP(wtc_pkg::WTC_SUPPLY_SOFT_KEEP)
  ) u_supply (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .soft_reset_i(soft_reset_i),
    .event_i(supply_event_i),
    .ro_i(8'h00),
    .clear_i(supply_clr),
    .value_o(supply_val)
  );

  wtc_status_byte #(
    .RC_MASK(wtc_pkg::WTC_DEVICE_RC_MASK),
    .RO_MASK(wtc_pkg::WTC_DEVICE_RO_MASK),
    .POR_VAL(wtc_pkg::WTC_DEVICE_POR_VAL),
    .SOFT_KEEP(wtc_pkg::WTC_DEVICE_SOFT_KEEP)
  ) u_device (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .soft_reset_i(soft_reset_i),
    .event_i(device_ev),
    .ro_i(device_ro),
    .clear_i(device_clr),
    .value_o(device_val)
  );

  // ****************************************
  // Outputs
  // ****************************************
  // Scratch byte reaches only the SPI read path, never ctrl_o, see (R7)
  always_comb begin
    ctrl_o.periodic_timer_wake_enable = s_r.wake_input[wtc_pkg::WTC_TIMER_WAKE_BIT];  // see (R1)
    ctrl_o.watchdog_stop_mode_disable = s_r.wake_input[wtc_pkg::WTC_WD_STOP_BIT];
    ctrl_o.wake_pin_wake_enable = s_r.wake_source[wtc_pkg::WTC_PIN_WAKE_BIT];
    ctrl_o.wake_pin_pull_select = s_r.pin_pull[1:0];  // see (R5)
    ctrl_o.periodic_timer_period = s_r.timer[2:0];
    periodic_timer_period_valid_o = s_r.timer[2:0] != wtc_pkg::WTC_PERIOD_RESERVED;
    if (periodic_timer_period_valid_o) begin
      periodic_timer_period_ms_o = wtc_pkg::WTC_PERIOD_MS[s_r.timer[2:0]];  // see (R6)
    end else begin
      periodic_timer_period_ms_o = 11'h000;
    end
  end

  assign spi_miso_o = s_r.miso;
  assign spi_miso_oe_o = s_r.miso_oe;

  // ****************************************
  // Checks
  // ****************************************
  chk_timer_wake_write: assert property (@(posedge clk_i) disable iff (reset_i) // see (R1)
    (commit && frame.clear && frame.addr == wtc_pkg::WTC_ADDR_WAKE_INPUT && !soft_reset_i
     && !restart_i && !wd_stop_hw_update_i)
    |=> (ctrl_o.periodic_timer_wake_enable == $past(s_r.shift_in[14]))
        && (ctrl_o.watchdog_stop_mode_disable == $past(s_r.shift_in[10])))
    else $error("wake input write not applied");

  chk_wd_stop_hw: assert property (@(posedge clk_i) disable iff (reset_i) // see (R2)
    (wd_stop_hw_update_i && !soft_reset_i && !restart_i)
    |=> ctrl_o.watchdog_stop_mode_disable == $past(wd_stop_hw_value_i))
    else $error("watchdog stop bit hardware update lost");

  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (reset_i) // see (R3)
    ((s_r.wake_input & ~wtc_pkg::WTC_WAKE_INPUT_MASK) == 8'h00)
    && ((s_r.timer & ~wtc_pkg::WTC_TIMER_MASK) == 8'h00)
    && ((s_r.pin_pull & ~wtc_pkg::WTC_PIN_PULL_MASK) == 8'h00)
    && ((s_r.wake_source & ~wtc_pkg::WTC_WAKE_SOURCE_MASK) == 8'h00))
    else $error("reserved control bit set");

  chk_pin_wake_soft: assert property (@(posedge clk_i) disable iff (reset_i) // see (R4)
    soft_reset_i |=> ctrl_o.wake_pin_wake_enable && ctrl_o.periodic_timer_period == 3'h0)
    else $error("soft reset values wrong");

  chk_scratch_keep: assert property (@(posedge clk_i) disable iff (reset_i) // see (R8)
    (soft_reset_i || (restart_i && !commit)) |=> $stable(s_r.scratch))
    else $error("scratch byte lost on reset or restart");

  chk_restart_values: assert property (@(posedge clk_i) disable iff (reset_i) // see (R17)
    (restart_i && !soft_reset_i)
    |=> !ctrl_o.watchdog_stop_mode_disable
        && (ctrl_o.periodic_timer_wake_enable == $past(ctrl_o.periodic_timer_wake_enable))
        && $stable(ctrl_o.wake_pin_pull_select) && $stable(ctrl_o.wake_pin_wake_enable)
        && $stable(ctrl_o.periodic_timer_period))
    else $error("restart values wrong");

  chk_status_read: assert property (@(posedge clk_i) disable iff (reset_i) // see (R13)
    (commit && !frame.clear && supply_event_i == 8'h00 && !soft_reset_i)
    |=> $stable(supply_val))
    else $error("status read altered flags");

  chk_status_clear: assert property (@(posedge clk_i) disable iff (reset_i) // see (R14)
    (supply_clr && supply_event_i == 8'h00 && !soft_reset_i) |=> supply_val == 8'h00)
    else $error("status clear did not clear");

  chk_fail_counter: assert property (@(posedge clk_i) disable iff (reset_i) // see (R21)
    (wd_trigger_ok_i && !watchdog_fail_counter_event_i)
    |=> device_val[wtc_pkg::WTC_WD_CNT_LSB +: 2] == 2'h0)
    else $error("fail counter not cleared by trigger");

endmodule : wtc_regs

// *** test/wtc_spi_master.sv ***
`timescale 1ns/1ps

// ****************************************
// SPI master model of the microcontroller
// ****************************************
module wtc_spi_master (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic mosi_o
);
  // Idle: CS high, SCK stands low
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end

  // Wait on falling clock edges, where all master pins move
  task automatic gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask : gap

  // One frame LSB first; nbits other than 16 gives a broken frame
  task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    gap(1);
    cs_n_o = 1'b0;
    gap(4);
    // Half periods of 5 clk keep each SCK phase above 4 clk
    for (int i = 0; i < nbits; i++) begin
      mosi_o = frame[i];
      gap(5);
      if (i >= 8 && i < 16) rd[i-8] = miso_i;
      sck_o = 1'b1;
      gap(5);
      sck_o = 1'b0;
    end
    gap(4);
    cs_n_o = 1'b1;
    // Released data line flips so no stale bit looks valid
    mosi_o = ~mosi_o;
    gap(8);
  endtask : xfer
endmodule : wtc_spi_master

// *** test/tb_wtc_regs.sv ***
`timescale 1ns/1ps

module tb_wtc_regs;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic soft_reset_i = 1'b0;
  logic restart_i = 1'b0;
  logic wd_stop_hw_update_i = 1'b0;
  logic wd_stop_hw_value_i = 1'b0;
  logic watchdog_fail_counter_event_i = 1'b0;
  logic wd_trigger_ok_i = 1'b0;
  logic [7:0] supply_event_i = 8'h00;
  logic [7:0] device_event_i = 8'h00;
  logic cs_n, sck, mosi, miso, miso_oe, per_valid;
  logic [10:0] per_ms;
  wtc_pkg::wtc_ctrl_type ctrl_o;
  int num_errors = 0;
  int total_checks = 0;
  logic oe_seen = 1'b0;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  wtc_regs wtc_regs_i (.clk_i(clk_i), .reset_i(reset_i), .soft_reset_i(soft_reset_i),
    .restart_i(restart_i), .spi_cs_n_i(cs_n), .spi_sck_i(sck), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .wd_stop_hw_update_i(wd_stop_hw_update_i),
    .wd_stop_hw_value_i(wd_stop_hw_value_i), .watchdog_fail_counter_event_i(watchdog_fail_counter_event_i),
    .wd_trigger_ok_i(wd_trigger_ok_i), .supply_event_i(supply_event_i),
    .device_event_i(device_event_i), .ctrl_o(ctrl_o),
    .periodic_timer_period_valid_o(per_valid), .periodic_timer_period_ms_o(per_ms));

  wtc_spi_master wtc_spi_master_i (.clk_i(clk_i), .miso_i(miso), .cs_n_o(cs_n),
    .sck_o(sck), .mosi_o(mosi));

  // Remembers whether MISO was ever enabled while a frame was open
  always @(negedge clk_i) begin
    if (cs_n === 1'b0 && miso_oe === 1'b1) oe_seen <= 1'b1;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Power-on reset, then three edges so synced CS settles high
  task automatic do_reset();
    reset_i = 1'b1;
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : do_reset

  // Mode one: write a control register or clear a status register
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rd;
    wtc_spi_master_i.xfer({d, 1'b1, a}, 16, rd);
  endtask : wr

  // Mode zero read; data byte all ones must not write anything
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] rd;
    wtc_spi_master_i.xfer({8'hFF, 1'b0, a}, 16, rd);
    chk($sformatf("reg %h", a), {3'h0, e}, {3'h0, rd});
  endtask : rchk

  // One-cycle pulses on event and mode inputs, then a settle gap
  task automatic ev(input logic [7:0] s, input logic [7:0] d, input logic [5:0] p);
    supply_event_i = s;
    device_event_i = d;
    {wd_stop_hw_update_i, wd_stop_hw_value_i, watchdog_fail_counter_event_i, wd_trigger_ok_i,
      soft_reset_i, restart_i} = p;
    @(negedge clk_i);
    supply_event_i = 8'h00;
    device_event_i = 8'h00;
    {wd_stop_hw_update_i, wd_stop_hw_value_i, watchdog_fail_counter_event_i, wd_trigger_ok_i,
      soft_reset_i, restart_i} = 6'h00;
    repeat (4) @(negedge clk_i);
  endtask : ev

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [6:0] ad [7] = '{7'h06, 7'h07, 7'h08, 7'h0C, 7'h1E, 7'h41, 7'h43};
    logic [7:0] ex [7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    chk("ctrl", 11'h020, {3'h0, ctrl_o});
    for (int i = 0; i < 7; i++) rchk(ad[i], ex[i]);
  endtask : t_reset

  // All ones into every control register; reserved bits must drop
  task automatic t_write();
    logic [6:0] ad [5] = '{7'h06, 7'h07, 7'h08, 7'h0C, 7'h1E};
    logic [7:0] mk [5] = '{8'h44, 8'h01, 8'h03, 8'h07, 8'hFF};
    for (int i = 0; i < 5; i++) wr(ad[i], 8'hFF);
    chk("ctrl", 11'h0FF, {3'h0, ctrl_o});
    for (int i = 0; i < 5; i++) rchk(ad[i], mk[i]);
    for (int i = 0; i < 4; i++) wr(ad[i], 8'h00);
    chk("ctrl", 11'h000, {3'h0, ctrl_o});
    wr(7'h1E, 8'hA5);
    chk("ctrl", 11'h000, {3'h0, ctrl_o});
  endtask : t_write

  // Every period code and pull code, reserved bits set as well
  task automatic t_period();
    int ms [8] = '{10, 20, 50, 100, 200, 1000, 2000, 0};
    for (int c = 0; c < 8; c++) begin
      wr(7'h0C, 8'hF8 | 8'(c));
      wr(7'h08, 8'hFC | 8'(c % 4));
      chk("period_ms", 11'(ms[c]), per_ms);
      chk("valid", {10'h0, c != 7}, {10'h0, per_valid});
      chk("pull", 11'(c % 4), {9'h0, ctrl_o.wake_pin_pull_select});
    end
    rchk(7'h0C, 8'h07);
  endtask : t_period

  // Hardware update, restart, soft reset and power-on reset
  task automatic t_resets();
    wr(7'h1E, 8'h5A);
    wr(7'h06, 8'h44);
    wr(7'h07, 8'h00);
    wr(7'h08, 8'h03);
    wr(7'h0C, 8'h05);
    ev(8'h00, 8'h00, 6'b100000);
    rchk(7'h06, 8'h40);
    ev(8'h00, 8'h00, 6'b110000);
    rchk(7'h06, 8'h44);
    ev(8'h00, 8'h00, 6'b000001);
    rchk(7'h06, 8'h40);
    rchk(7'h07, 8'h00);
    rchk(7'h08, 8'h03);
    rchk(7'h0C, 8'h05);
    rchk(7'h1E, 8'h5A);
    ev(8'h00, 8'h00, 6'b000010);
    chk("ctrl", 11'h020, {3'h0, ctrl_o});
    rchk(7'h1E, 8'h5A);
    rchk(7'h41, 8'h80);
    do_reset();
    rchk(7'h1E, 8'h00);
  endtask : t_resets

  // Status read, clear, read-only counter and a short frame
  task automatic t_status();
    logic [7:0] rd;
    ev(8'h06, 8'h00, 6'b000000);
    rchk(7'h41, 8'h84);
    rchk(7'h41, 8'h84);
    wtc_spi_master_i.xfer({8'hFF, 1'b1, 7'h41}, 16, rd);
    rchk(7'h41, 8'h00);
    ev(8'h00, 8'h11, 6'b001000);
    ev(8'h00, 8'h00, 6'b001000);
    rchk(7'h43, 8'h19);
    wr(7'h43, 8'h00);
    rchk(7'h43, 8'h08);
    ev(8'h00, 8'h00, 6'b000100);
    rchk(7'h43, 8'h00);
    wtc_spi_master_i.xfer({8'h44, 1'b1, 7'h06}, 15, rd);
    rchk(7'h06, 8'h00);
    rchk(7'h43, 8'h02);
    chk("miso_oe idle", 11'h000, {10'h0, miso_oe});
    chk("miso_oe in frame", 11'h001, {10'h0, oe_seen});
  endtask : t_status

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    do_reset();
    t_reset();
    t_write();
    t_period();
    t_resets();
    t_status();
    finish_test();
  end

  // About 12k cycles expected; five times that means a hang
  initial begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    finish_test();
  end
endmodule : tb_wtc_regs
